// ===== rdst_err_bank.sv
// One copy of the access error flags: sticky, cleared by writing ones.
// Assumes set and clear pulses come from logic on the same clock.
`include "rdst_map.svh"

module rdst_err_bank
   import rdst_pkg::*;
#(
   parameter int unsigned WIDTH = `RDST_ERR_W
)
(
   // Clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   // Events and clears
   input  wire logic [WIDTH-1:0] set_i,
   input  wire logic [WIDTH-1:0] clr_i,
   // Flags
   output logic      [WIDTH-1:0] flags_o
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_flag
         always_ff @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
               flags_o[i] <= 1'b0;
            else if (set_i[i])
               flags_o[i] <= 1'b1;
            else if (clr_i[i])
               flags_o[i] <= 1'b0;
         end
      end
   endgenerate

endmodule : rdst_err_bank

// ===== rdst_map.svh
// Offsets, field positions and fixed codes of the redistributor status register group.
// Included by the package and the design files; definitions only.
`ifndef RDST_MAP_SVH
`define RDST_MAP_SVH

// Byte offsets within the redistributor frame
`define RDST_OFF_CFG_LO      16'h0008
`define RDST_OFF_CFG_HI      16'h000C
`define RDST_OFF_STATUS      16'h0010
`define RDST_OFF_SETPEND_LO  16'h0040
`define RDST_OFF_SETPEND_HI  16'h0044
`define RDST_OFF_SYNC        16'h00C0
`define RDST_OFF_SYNC_HI     16'h00C4

// Error status flag positions
`define RDST_ERR_WR_RO       3
`define RDST_ERR_RD_WO       2
`define RDST_ERR_WR_RSV      1
`define RDST_ERR_RD_RSV      0
`define RDST_ERR_W           4
`define RDST_ERR_RESET       4'h0

// Configuration info field positions
`define RDST_CFG_AFF_LSB     32
`define RDST_CFG_SHARE_LSB   24
`define RDST_CFG_PROC_LSB    8
`define RDST_CFG_POWER_GROUP_DISABLE_SUPPORT_BIT    5
`define RDST_CFG_LAST_BIT    4
`define RDST_CFG_DIRECT_BIT  3
`define RDST_CFG_VIRT_BIT    1
`define RDST_CFG_PHYS_BIT    0

// Table sharing level codes
`define RDST_SHARE_ALL       2'h0
`define RDST_SHARE_L3        2'h1
`define RDST_SHARE_L32       2'h2
`define RDST_SHARE_L321      2'h3

// Smallest locality interrupt identifier
`define RDST_MIN_LOC_ID      32'h0000_2000
// Operation sync busy bit
`define RDST_SYNC_BUSY_BIT   0

`endif

// ===== rdst_pkg.sv
// Types shared by the redistributor status register group.
// Assumes rdst_map.svh is on the include path.
`include "rdst_map.svh"

package rdst_pkg;

   // One register access as presented by the frame decoder
   typedef struct packed {
      logic        write;
      logic        wide;
      logic        secure;
      logic [15:0] addr;
      logic [63:0] wdata;
   } rdst_req_s;

   // Read answer, one cycle after the access is taken
   typedef struct packed {
      logic        valid;
      logic [63:0] rdata;
   } rdst_rsp_s;

   // Access violation events, in flag bit order 3..0
   typedef struct packed {
      logic wr_ro;
      logic rd_wo;
      logic wr_rsv;
      logic rd_rsv;
   } rdst_err_s;

   // What an address decodes to
   typedef enum logic [1:0] {
      RDST_LOC_RW,
      RDST_LOC_RO,
      RDST_LOC_WO,
      RDST_LOC_RSV
   } rdst_loc_e;

endpackage : rdst_pkg

// ===== rdst_regs.sv
// Redistributor status register group: access error flags, operation sync, config info.
// Assumes one access per taken request from the frame decoder on core_clk_i.
//
// Behaviour
// - Write to read-only location sets bit 3
// - Read of write-only location sets bit 2
// - Write to reserved location sets bit 1
// - Read of reserved location sets bit 0
// - Flags clear only by writing one
// - Absent status register reads zero, ignores writes
// - Separate secure and non-secure flag copies
// - Busy while clear or invalidate writes pending
// - Busy also covers table base operations
// - Stalling sync read always returns busy zero
// - Sync register read-only from every state
// - Affinity levels 3..0 in bits 63:32
// - Bits 25:24 give table sharing level
// - Bits 23:8 hold the processor number
// - Bit 5 reports power-group disable support
// - Bit 4 marks last redistributor page
// - Bit 3 reports direct injection support
// - Bit 1 reports virtual interrupt support
// - Bit 0 reports physical interrupt support
// - Set-pending ignored if pending, unimplemented, disabled
// - Set-pending id in 31:0, zero-extended
`include "rdst_map.svh"

module rdst_regs
   import rdst_pkg::*;
#(
   parameter logic        STATUS_PRESENT = 1'b1,
   parameter logic        TWO_SECURITY   = 1'b1,
   parameter logic        SYNC_STALLS    = 1'b0,
   parameter logic [31:0] AFFINITY       = 32'h0000_0000,
   parameter logic [1:0]  SHARE_LEVEL    = `RDST_SHARE_ALL,
   parameter logic [15:0] PROC_NUMBER    = 16'h0000,
   parameter logic        POWER_GROUP_DISABLE_SUPPORT_SUPPORT   = 1'b0,
   parameter logic        LAST_PAGE      = 1'b1,
   parameter logic        DIRECT_SUPPORT = 1'b1,
   parameter logic        VIRT_SUPPORT   = 1'b0,
   parameter logic        PHYS_SUPPORT   = 1'b1,
   parameter int unsigned ID_BITS        = 16,
   parameter int unsigned OP_CNT_W       = 4
)
(
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // Register access
   input  wire logic        req_valid_i,
   input  wire rdst_req_s   req_i,
   output logic             req_ready_o,
   output rdst_rsp_s        rsp_o,
   // Maintenance operations of the surrounding redistributor
   input  wire logic        op_start_i,
   input  wire logic        op_done_i,
   output logic             busy_o,
   // Set-pending path
   input  wire logic        locality_interrupts_on_i,
   output logic [31:0]      pend_query_id_o,
   input  wire logic        id_pending_i,
   output logic             set_pend_valid_o,
   output logic [31:0]      set_pend_id_o,
   // Flag view
   output logic [3:0]       flags_secure_o,
   output logic [3:0]       flags_nonsec_o
);

   localparam logic [31:0] ID_LIMIT_MASK = 32'(~((64'h1 << ID_BITS) - 64'h1));

   // Address decode
   wire logic hit_cfg    = (req_i.addr == `RDST_OFF_CFG_LO) || (req_i.addr == `RDST_OFF_CFG_HI);
   wire logic hit_status = (req_i.addr == `RDST_OFF_STATUS);
   wire logic hit_set_lo = (req_i.addr == `RDST_OFF_SETPEND_LO);
   wire logic hit_set    = hit_set_lo || (req_i.addr == `RDST_OFF_SETPEND_HI);
   wire logic hit_sync   = (req_i.addr == `RDST_OFF_SYNC) || (req_i.addr == `RDST_OFF_SYNC_HI);

   rdst_loc_e loc;
   assign loc = hit_status ? RDST_LOC_RW :
                (hit_cfg || hit_sync) ? RDST_LOC_RO :
                hit_set ? RDST_LOC_WO : RDST_LOC_RSV;

   wire logic take   = req_valid_i && req_ready_o;
   wire logic is_wr  = req_i.write;
   wire logic is_rd  = !req_i.write;
   wire logic bank   = TWO_SECURITY && req_i.secure;

   // Busy tracking
   logic busy;

   rdst_sync_tracker #(
      .CNT_W (OP_CNT_W)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .op_start_i (op_start_i),
      .op_done_i  (op_done_i),
      .busy_o     (busy)
   );

   assign busy_o = busy;
   // A stalling sync read waits here until the tracker drains
   wire logic sync_hold = SYNC_STALLS && req_valid_i && is_rd && hit_sync && busy;
   assign req_ready_o = !sync_hold;

   // Violation events
   rdst_err_s ev;
   assign ev.wr_ro  = take && is_wr && (loc == RDST_LOC_RO);
   assign ev.rd_wo  = take && is_rd && (loc == RDST_LOC_WO);
   assign ev.wr_rsv = take && is_wr && (loc == RDST_LOC_RSV);
   assign ev.rd_rsv = take && is_rd && (loc == RDST_LOC_RSV);

   wire logic [3:0] ev_bits  = STATUS_PRESENT ? ev : 4'h0;
   wire logic       st_write = take && is_wr && hit_status && STATUS_PRESENT;
   wire logic [3:0] clr_bits = st_write ? req_i.wdata[3:0] : 4'h0;

   logic [1:0][3:0] flags;

   genvar b;
   generate
      for (b = 0; b < 2; b++)
      begin : g_bank
         wire logic sel = (bank == (b == 1));
         rdst_err_bank #(
            .WIDTH (`RDST_ERR_W)
         ) u_bank (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .set_i      (sel ? ev_bits : 4'h0),
            .clr_i      (sel ? clr_bits : 4'h0),
            .flags_o    (flags[b])
         );
      end
   endgenerate

   assign flags_nonsec_o = flags[0];
   assign flags_secure_o = flags[1];

   // Configuration info word
   wire logic [63:0] cfg_word = {AFFINITY,
                                 6'h00, SHARE_LEVEL, PROC_NUMBER,
                                 2'h0, POWER_GROUP_DISABLE_SUPPORT_SUPPORT, LAST_PAGE, DIRECT_SUPPORT,
                                 1'b0, VIRT_SUPPORT, PHYS_SUPPORT};

   // Read data selection
   wire logic [31:0] status_word = {28'h0, flags[bank]};
   wire logic [31:0] sync_word   = {31'h0, (busy && !SYNC_STALLS)};
   wire logic [63:0] rd_data =
      !is_rd ? 64'h0 :
      (req_i.addr == `RDST_OFF_CFG_LO) ? (req_i.wide ? cfg_word : {32'h0, cfg_word[31:0]}) :
      (req_i.addr == `RDST_OFF_CFG_HI) ? {32'h0, cfg_word[63:32]} :
      hit_status ? (STATUS_PRESENT ? {32'h0, status_word} : 64'h0) :
      (req_i.addr == `RDST_OFF_SYNC) ? {32'h0, sync_word} : 64'h0;

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         rsp_o <= '0;
      else
         rsp_o <= '{valid: take && is_rd, rdata: rd_data};
   end

   // Set-pending requests
   wire logic [31:0] set_id   = req_i.wdata[31:0];
   wire logic        id_impl  = (set_id >= `RDST_MIN_LOC_ID) && ((set_id & ID_LIMIT_MASK) == 32'h0);
   wire logic        set_wr   = take && is_wr && hit_set_lo;
   wire logic        set_fire = set_wr && locality_interrupts_on_i && id_impl && !id_pending_i;

   assign pend_query_id_o = set_id;

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         set_pend_valid_o <= 1'b0;
      else
         set_pend_valid_o <= set_fire;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         set_pend_id_o <= 32'h0;
      else if (set_fire)
         set_pend_id_o <= set_id;
   end

   // Checks
   sequence s_wr_ro;
      take && is_wr && (loc == RDST_LOC_RO) && STATUS_PRESENT;
   endsequence

   sequence s_rd_wo;
      take && is_rd && (loc == RDST_LOC_WO) && STATUS_PRESENT;
   endsequence

   sequence s_set_write;
      set_wr && locality_interrupts_on_i && id_impl && !id_pending_i;
   endsequence

   sequence s_cfg_low_read;
      take && is_rd && (req_i.addr == `RDST_OFF_CFG_LO);
   endsequence

   sequence s_sync_read;
      take && is_rd && hit_sync;
   endsequence

   chk_wr_ro_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_wr_ro |=> flags[$past(bank)][`RDST_ERR_WR_RO])
      else $error("write to read-only location not flagged");

   chk_rd_wo_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_rd_wo |=> flags[$past(bank)][`RDST_ERR_RD_WO])
      else $error("read of write-only location not flagged");

   chk_wr_rsv_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_wr && (loc == RDST_LOC_RSV) && STATUS_PRESENT)
      |=> flags[$past(bank)][`RDST_ERR_WR_RSV])
      else $error("reserved write not flagged");

   chk_rd_rsv_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_rd && (loc == RDST_LOC_RSV) && STATUS_PRESENT)
      |=> flags[$past(bank)][`RDST_ERR_RD_RSV] && rsp_o.valid && (rsp_o.rdata == 64'h0))
      else $error("reserved read not flagged or not zero");

   chk_clear_cause: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (|($past(flags[0]) & ~flags[0]))
      |-> $past(st_write && !bank && (|(req_i.wdata[3:0] & flags[0]))))
      else $error("non-secure flag cleared without a write of one");

   chk_absent_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_rd && hit_status && !STATUS_PRESENT) |=> (rsp_o.rdata == 64'h0))
      else $error("absent status register read non-zero");

   chk_bank_split: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && TWO_SECURITY && !req_i.secure) |=> $stable(flags[1]))
      else $error("non-secure access changed secure flags");

   chk_busy_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (op_start_i && !op_done_i) |=> busy)
      else $error("busy not raised after an operation start");

   chk_busy_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_rd && (req_i.addr == `RDST_OFF_SYNC) && !SYNC_STALLS)
      |=> (rsp_o.rdata[`RDST_SYNC_BUSY_BIT] == $past(busy)))
      else $error("sync busy bit does not follow tracker");

   chk_sync_stall: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_rd && hit_sync && SYNC_STALLS) |=> (rsp_o.rdata == 64'h0))
      else $error("stalling sync read returned busy");

   chk_cfg_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_rd && req_i.wide && (req_i.addr == `RDST_OFF_CFG_LO))
      |=> rsp_o.valid && (rsp_o.rdata == cfg_word))
      else $error("config info read mismatch");

   chk_set_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (set_wr && (!locality_interrupts_on_i || id_pending_i || !id_impl)) |=> !set_pend_valid_o)
      else $error("ignored set-pending write took effect");

   chk_set_id: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_set_write |=> set_pend_valid_o && (set_pend_id_o == $past(req_i.wdata[31:0])))
      else $error("set-pending id not forwarded");

   chk_cfg_share: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_cfg_low_read |=> rsp_o.valid && (rsp_o.rdata[`RDST_CFG_SHARE_LSB +: 2] == SHARE_LEVEL)
                         && (rsp_o.rdata[`RDST_CFG_PROC_LSB +: 16] == PROC_NUMBER))
      else $error("config sharing level or processor number mismatch");

   chk_cfg_page: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_cfg_low_read |=> (rsp_o.rdata[`RDST_CFG_POWER_GROUP_DISABLE_SUPPORT_BIT] == POWER_GROUP_DISABLE_SUPPORT_SUPPORT)
                         && (rsp_o.rdata[`RDST_CFG_LAST_BIT] == LAST_PAGE))
      else $error("config power group or last page bit mismatch");

   chk_cfg_inject: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_cfg_low_read |=> (rsp_o.rdata[`RDST_CFG_DIRECT_BIT] == DIRECT_SUPPORT)
                         && (rsp_o.rdata[`RDST_CFG_VIRT_BIT] == VIRT_SUPPORT)
                         && (rsp_o.rdata[`RDST_CFG_PHYS_BIT] == PHYS_SUPPORT))
      else $error("config support bits mismatch");

   chk_cfg_high: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_rd && (req_i.addr == `RDST_OFF_CFG_HI))
      |=> rsp_o.valid && (rsp_o.rdata == {32'h0, AFFINITY}))
      else $error("config upper word mismatch");

   chk_cfg_rsvd: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_cfg_low_read |=> (rsp_o.rdata[31:26] == 6'h00) && (rsp_o.rdata[7:6] == 2'h0)
                         && !rsp_o.rdata[2])
      else $error("config reserved bits not zero");

   chk_status_rsvd: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_rd && hit_status) |=> (rsp_o.rdata[63:4] == 60'h0))
      else $error("status reserved bits not zero");

   chk_sync_rsvd: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_sync_read |=> rsp_o.valid && (rsp_o.rdata[63:1] == 63'h0))
      else $error("sync reserved bits not zero");

   chk_sync_ro: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_wr && hit_sync && STATUS_PRESENT) |=> flags[$past(bank)][`RDST_ERR_WR_RO])
      else $error("write to sync register not treated as read-only");

   chk_sec_bank: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && TWO_SECURITY && req_i.secure) |=> $stable(flags[0]))
      else $error("secure access changed non-secure flags");

   chk_sec_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (|($past(flags[1]) & ~flags[1]))
      |-> $past(st_write && bank && (|(req_i.wdata[3:0] & flags[1]))))
      else $error("secure flag cleared without a write of one");

   chk_zero_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (st_write && (req_i.wdata[3:0] == 4'h0))
      |=> (flags[$past(bank)] == $past(flags[bank])))
      else $error("status write of zero changed flags");

   chk_w1c_done: assert property (@(posedge core_clk_i) disable iff (rst_i)
      st_write
      |=> ((flags[$past(bank)] & $past(req_i.wdata[3:0])) == 4'h0))
      else $error("write of one did not clear flag");

   chk_rd_wo_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_rd_wo |=> rsp_o.valid && (rsp_o.rdata == 64'h0))
      else $error("read of write-only location not zero");

   chk_set_only: assert property (@(posedge core_clk_i) disable iff (rst_i)
      set_pend_valid_o |-> $past(set_wr))
      else $error("set-pending pulse without a write");

   chk_set_hi: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && is_wr && hit_set && !hit_set_lo) |=> !set_pend_valid_o)
      else $error("upper set-pending word took effect");

   chk_ready_free: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !busy |-> req_ready_o)
      else $error("access refused while idle");

   chk_busy_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!busy && !op_start_i) |=> !busy)
      else $error("busy raised without an operation start");

   chk_absent_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !STATUS_PRESENT |-> (flags == 8'h00))
      else $error("absent status register holds flags");

endmodule : rdst_regs

// ===== rdst_regs_tb.sv
// Self-checking bench for the redistributor status register group.
// Assumes rdst_pkg and rdst_map.svh are compiled first; drives the access port directly.
`include "rdst_map.svh"

module rdst_regs_tb
   import rdst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] AFF   = 32'h1234_5678;
   localparam logic [15:0] PROCN = 16'hA5C3;
   localparam logic [63:0] CFG   = {AFF, 6'h00, `RDST_SHARE_L32, PROCN, 2'h0,
                                    1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
   localparam logic [31:0] BAD_ID [4] = '{32'h0000_1FFF, 32'h0001_0000,
                                          32'h0000_2006, 32'h0000_2007};

   logic        core_clk_i;
   logic        rst_i;
   logic        req_valid_i;
   rdst_req_s   req_i;
   logic        req_ready_o;
   rdst_rsp_s   rsp_o;
   logic        op_start_i;
   logic        op_done_i;
   logic        busy_o;
   logic        loc_on;
   logic [31:0] pend_query_id_o;
   logic        id_pending_i;
   logic        set_pend_valid_o;
   logic [31:0] set_pend_id_o;
   logic [3:0]  flags_secure_o;
   logic [3:0]  flags_nonsec_o;
   logic [63:0] rd_q [$];
   logic [31:0] pend_q [$];
   logic [31:0] seed;
   logic [31:0] r;
   logic        sec_hit;
   logic        ns_hit;
   int          bad_count;
   int          n_tests;

   rdst_regs #(
      .AFFINITY     (AFF),
      .SHARE_LEVEL  (`RDST_SHARE_L32),
      .PROC_NUMBER  (PROCN),
      .POWER_GROUP_DISABLE_SUPPORT_SUPPORT (1'b1)
   ) dut (
      .core_clk_i               (core_clk_i),
      .rst_i                    (rst_i),
      .req_valid_i              (req_valid_i),
      .req_i                    (req_i),
      .req_ready_o              (req_ready_o),
      .rsp_o                    (rsp_o),
      .op_start_i               (op_start_i),
      .op_done_i                (op_done_i),
      .busy_o                   (busy_o),
      .locality_interrupts_on_i (loc_on),
      .pend_query_id_o          (pend_query_id_o),
      .id_pending_i             (id_pending_i),
      .set_pend_valid_o         (set_pend_valid_o),
      .set_pend_id_o            (set_pend_id_o),
      .flags_secure_o           (flags_secure_o),
      .flags_nonsec_o           (flags_nonsec_o)
   );

   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : next_rand

   task automatic final_report();
      if (bad_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   task automatic check_data(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_data

   task automatic check_id(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_id

   // Called just after an edge; holds the request until taken, leaves valid high
   task automatic acc(input logic wr, input logic wide, input logic sec,
                      input logic [15:0] a, input logic [63:0] wd, input logic [63:0] exp);
      int i;
      req_valid_i = 1'b1;
      req_i = '{write: wr, wide: wide, secure: sec, addr: a, wdata: wd};
      i = 0;
      do
      begin
         @(posedge core_clk_i);
         i++;
      end
      while (req_ready_o !== 1'b1 && i < 50);
      if (i >= 50)
      begin
         bad_count++;
         final_report();
      end
      if (!wr)
         rd_q.push_back(exp);
      #1;
   endtask : acc

   task automatic idle(input int n);
      req_valid_i = 1'b0;
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : idle

   task automatic op(input logic s, input logic d);
      op_start_i = s;
      op_done_i  = d;
      @(posedge core_clk_i);
      #1;
   endtask : op

   // Takes the oldest note whenever a result appears
   always @(negedge core_clk_i)
      if (rst_i === 1'b0)
      begin
         if (rsp_o.valid === 1'b1)
            check_data(rsp_o.rdata, rd_q.size() ? rd_q.pop_front() : ~rsp_o.rdata);
         if (set_pend_valid_o === 1'b1)
            check_id(set_pend_id_o, pend_q.size() ? pend_q.pop_front() : ~set_pend_id_o);
      end

   initial
   begin
      repeat (5000) @(posedge core_clk_i);
      bad_count++;
      final_report();
   end

   initial
   begin
      seed = 32'hC542F948;
      bad_count = 0;
      n_tests = 0;
      rst_i = 1'b1;
      req_valid_i = 1'b0;
      req_i = '0;
      op_start_i = 1'b0;
      op_done_i = 1'b0;
      loc_on = 1'b1;
      id_pending_i = 1'b0;
      sec_hit = 1'b0;
      ns_hit = 1'b0;
      repeat (16) @(posedge core_clk_i);
      #1;
      rst_i = 1'b0;
      acc(0, 0, 1, `RDST_OFF_STATUS, 0, 0);
      acc(0, 0, 0, `RDST_OFF_STATUS, 0, 0);
      acc(0, 1, 0, `RDST_OFF_CFG_LO, 0, CFG);
      acc(0, 0, 1, `RDST_OFF_CFG_LO, 0, {32'h0, CFG[31:0]});
      acc(0, 0, 0, `RDST_OFF_CFG_HI, 0, {32'h0, CFG[63:32]});
      acc(0, 0, 1, `RDST_OFF_SYNC_HI, 0, 0);
      // Violations in the secure copy, back to back
      acc(1, 0, 1, `RDST_OFF_CFG_LO, {next_rand(), next_rand()}, 0);
      acc(1, 0, 1, `RDST_OFF_SYNC, {next_rand(), next_rand()}, 0);
      acc(0, 0, 1, `RDST_OFF_SETPEND_LO, 0, 0);
      acc(1, 0, 1, 16'h0100, {next_rand(), next_rand()}, 0);
      acc(0, 0, 1, 16'h0104, 0, 0);
      idle(1);
      check_data({60'h0, flags_secure_o}, 64'hF);
      acc(0, 0, 1, `RDST_OFF_STATUS, 0, 64'hF);
      acc(0, 0, 0, `RDST_OFF_STATUS, 0, 0);
      acc(1, 0, 1, `RDST_OFF_STATUS, 0, 0);
      r = next_rand();
      acc(1, 0, 1, `RDST_OFF_STATUS, {r, r[31:4], 4'h5}, 0);
      acc(0, 0, 1, `RDST_OFF_STATUS, 0, 64'hA);
      acc(1, 0, 0, 16'h0200, {next_rand(), next_rand()}, 0);
      acc(1, 0, 1, `RDST_OFF_STATUS, 64'hA, 0);
      idle(1);
      acc(0, 0, 0, `RDST_OFF_STATUS, 0, 64'h2);
      acc(0, 0, 1, `RDST_OFF_STATUS, 0, 0);
      check_data({60'h0, flags_nonsec_o}, 64'h2);
      acc(1, 0, 0, `RDST_OFF_STATUS, 64'h2, 0);
      idle(1);
      // Outstanding maintenance operations
      op(1, 0);
      op(1, 0);
      op(1, 1);
      op(0, 0);
      check_data({63'h0, busy_o}, 64'h1);
      acc(0, 0, 1, `RDST_OFF_SYNC, 0, 64'h1);
      idle(1);
      op(0, 1);
      op(0, 0);
      check_data({63'h0, busy_o}, 64'h1);
      op(0, 1);
      op(0, 0);
      check_data({63'h0, busy_o}, 64'h0);
      acc(0, 0, 0, `RDST_OFF_SYNC, 0, 0);
      // Set-pending accepted and ignored cases
      r = next_rand();
      pend_q.push_back(32'h0000_2005);
      acc(1, 1, 1, `RDST_OFF_SETPEND_LO, {r, 32'h0000_2005}, 0);
      check_id(pend_query_id_o, 32'h0000_2005);
      for (int k = 0; k < 4; k++)
      begin
         id_pending_i = (k == 2);
         loc_on = (k != 3);
         acc(1, 0, k[0], `RDST_OFF_SETPEND_LO, {next_rand(), BAD_ID[k]}, 0);
      end
      id_pending_i = 1'b0;
      loc_on = 1'b1;
      pend_q.push_back(32'h0000_FFFF);
      acc(1, 0, 0, `RDST_OFF_SETPEND_LO, 64'h0000_FFFF, 0);
      idle(1);
      acc(0, 0, 1, `RDST_OFF_STATUS, 0, 0);
      // Random reserved reads in both security states
      for (int k = 0; k < 8; k++)
      begin
         r = next_rand();
         sec_hit = sec_hit | r[0];
         ns_hit = ns_hit | ~r[0];
         acc(0, r[1], r[0], 16'h0400 + {6'h0, r[9:2], 2'b00}, 0, 0);
      end
      idle(1);
      acc(0, 0, 1, `RDST_OFF_STATUS, 0, {63'h0, sec_hit});
      acc(0, 0, 0, `RDST_OFF_STATUS, 0, {63'h0, ns_hit});
      idle(3);
      check_data(64'(rd_q.size() + pend_q.size()), 64'h0);
      final_report();
   end
endmodule : rdst_regs_tb

// ===== rdst_sync_tracker.sv
// Counts maintenance operations that are started but not yet finished.
// Assumes start and done are single-cycle pulses on the same clock.
module rdst_sync_tracker
   import rdst_pkg::*;
#(
   parameter int unsigned CNT_W = 4
)
(
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   // Operation events
   input  wire logic op_start_i,
   input  wire logic op_done_i,
   // State
   output logic      busy_o
);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   wire logic        inc = op_start_i && !op_done_i && (cnt_reg != {CNT_W{1'b1}});
   wire logic        dec = op_done_i && !op_start_i && (cnt_reg != '0);

   assign cnt_next = inc ? CNT_W'(cnt_reg + 1'b1) :
                     dec ? CNT_W'(cnt_reg - 1'b1) : cnt_reg;

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end

   assign busy_o = (cnt_reg != '0);

endmodule : rdst_sync_tracker
